// *** sdram_dll_mode_load.sv ***
/*
  write clock delay loop control and status, and load mode command
  issue for the sdram interface, behind an avalon-mm slave.
  assumes a same-clock scheduler that reports all banks idle and
  yields the command bus while bus_hold_out is high; early/late
  phase detector pins are asynchronous and are synchronised here.
*/
// Functional notes
// - writing load bit 1 with loop enabled copies delay field into counter.
// - while load bit is set the tracking counter stays frozen.
// - phase bit picks target: 0 is period/5, 1 is period/4.
// - phase select is ignored while the loop is disabled.
// - status bit 1 is high on counter underflow, zero in range.
// - status bit 0 is high on counter overflow, zero in range.
// - status bit 2, lock, always reads zero.
// - a mode register write issues one load mode command, nothing more.
// - mode register load mode command drives both bank lines low.
// - legacy and new mode addresses share one stored register.
// - extended mode write issues load mode with bank lines 0,1.
// - extended bits 9:3 are stored and sent unchanged on address.
// - mode bit 8 is sent to memory to reset its loop.
// - extended bits 2,1,0 (fet switch, drive, loop) forwarded to memory.
// - delay field drives delay while loop disabled and feeds loads.
// - signed write offset adjusts write clock delay in both modes.
module sdram_dll_mode_load #(
  parameter int PERIOD_STEPS = 152
) (
  input  wire logic        ref_clk_in,
  input  wire logic        rst_in,
  input  wire logic [7:0]  avs_address_in,
  input  wire logic        avs_read_in,
  input  wire logic        avs_write_in,
  input  wire logic [31:0] avs_writedata_in,
  input  wire logic [3:0]  avs_byteenable_in,
  output logic      [31:0] avs_readdata_out,
  output logic             avs_waitrequest_out,
  input  wire logic        delay_early_in,
  input  wire logic        delay_late_in,
  input  wire logic        banks_idle_in,
  output logic             bus_hold_out,
  output logic      [7:0]  delay_tap_out,
  output logic      [7:0]  delay_target_out,
  output logic      [5:0]  write_clock_offset_out,
  output logic             sdram_cs_n_out,
  output logic             sdram_ras_n_out,
  output logic             sdram_cas_n_out,
  output logic             sdram_we_n_out,
  output logic      [1:0]  sdram_ba_out,
  output logic      [11:0] sdram_addr_out
);

  // ****************************************
  // register bus
  // ****************************************
  logic [31:0] ctrl_r, ctrl_nxt;
  logic [31:0] mode_r, mode_nxt;
  logic [31:0] ext_r, ext_nxt;
  logic [31:0] rdata_r, rdata_nxt;
  logic        rd_done_r, rd_done_nxt;
  logic [31:0] be_mask;
  logic        wr_ctrl, wr_mode, wr_ext;
  logic [31:0] stat_word;

  assign be_mask = {{8{avs_byteenable_in[3]}}, {8{avs_byteenable_in[2]}},
                    {8{avs_byteenable_in[1]}}, {8{avs_byteenable_in[0]}}};
  assign wr_ctrl = avs_write_in
                   && avs_address_in == sdram_dll_mode_pkg::OFS_DLL_CTRL;
  assign wr_mode = avs_write_in
                   && (avs_address_in == sdram_dll_mode_pkg::OFS_MODE_NEW
                   || avs_address_in == sdram_dll_mode_pkg::OFS_MODE_LEGACY);
  assign wr_ext  = avs_write_in
                   && avs_address_in == sdram_dll_mode_pkg::OFS_EXT_MODE;
  // reads take one wait cycle, writes none
  assign avs_waitrequest_out = avs_read_in & ~rd_done_r;
  assign avs_readdata_out    = rdata_r;

  always_comb
  begin
    ctrl_nxt    = ctrl_r;
    mode_nxt    = mode_r;
    ext_nxt     = ext_r;
    rd_done_nxt = avs_read_in & ~rd_done_r;
    rdata_nxt   = rdata_r;
    if (wr_ctrl)
    begin
      ctrl_nxt = (ctrl_r & ~(be_mask & sdram_dll_mode_pkg::CTRL_WMASK))
               | (avs_writedata_in & be_mask
                  & sdram_dll_mode_pkg::CTRL_WMASK);
    end
    if (wr_mode)
    begin
      mode_nxt = (mode_r & ~(be_mask & sdram_dll_mode_pkg::MODE_WMASK))
               | (avs_writedata_in & be_mask
                  & sdram_dll_mode_pkg::MODE_WMASK);
    end
    if (wr_ext)
    begin
      ext_nxt = (ext_r & ~(be_mask & sdram_dll_mode_pkg::EXT_WMASK))
              | (avs_writedata_in & be_mask & sdram_dll_mode_pkg::EXT_WMASK);
    end
    if (avs_read_in && !rd_done_r)
    begin
      case (avs_address_in)
        sdram_dll_mode_pkg::OFS_DLL_CTRL:    rdata_nxt = ctrl_r;
        sdram_dll_mode_pkg::OFS_DLL_STAT:    rdata_nxt = stat_word;
        sdram_dll_mode_pkg::OFS_MODE_NEW:    rdata_nxt = mode_r;
        sdram_dll_mode_pkg::OFS_MODE_LEGACY: rdata_nxt = mode_r;
        sdram_dll_mode_pkg::OFS_EXT_MODE:    rdata_nxt = ext_r;
        default:                             rdata_nxt = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge ref_clk_in)
  begin
    if (rst_in)
    begin
      ctrl_r    <= sdram_dll_mode_pkg::CTRL_RESET;
      mode_r    <= sdram_dll_mode_pkg::MODE_RESET;
      ext_r     <= sdram_dll_mode_pkg::EXT_RESET;
      rdata_r   <= 32'h0000_0000;
      rd_done_r <= 1'b0;
    end
    else
    begin
      ctrl_r    <= ctrl_nxt;
      mode_r    <= mode_nxt;
      ext_r     <= ext_nxt;
      rdata_r   <= rdata_nxt;
      rd_done_r <= rd_done_nxt;
    end
  end

  // ****************************************
  // delay loop tracking
  // ****************************************
  logic       early_s1_r, early_s2_r, late_s1_r, late_s2_r;
  logic [7:0] cnt_r, cnt_nxt;
  logic       ovf_r, ovf_nxt;
  logic       udf_r, udf_nxt;
  logic [7:0] tap_r, tap_nxt;
  logic       loop_en, loop_load, load_now;
  logic [7:0] manual_dly;
  localparam logic [7:0] TARGET_72 =
    8'(PERIOD_STEPS / sdram_dll_mode_pkg::PHASE72_DIV);
  localparam logic [7:0] TARGET_90 =
    8'(PERIOD_STEPS / sdram_dll_mode_pkg::PHASE90_DIV);

  assign loop_en    = ctrl_r[sdram_dll_mode_pkg::CTRL_ENABLE_BIT];
  assign loop_load  = ctrl_r[sdram_dll_mode_pkg::CTRL_LOAD_BIT];
  assign manual_dly = ctrl_nxt[sdram_dll_mode_pkg::CTRL_DLY_LSB +: 8];
  assign load_now   = wr_ctrl && avs_byteenable_in[0]
                   && avs_writedata_in[sdram_dll_mode_pkg::CTRL_LOAD_BIT]
                   && ctrl_nxt[sdram_dll_mode_pkg::CTRL_ENABLE_BIT];

  always_comb
  begin
    cnt_nxt = cnt_r;
    ovf_nxt = ovf_r;
    udf_nxt = udf_r;
    if (!loop_en)
    begin
      ovf_nxt = 1'b0;
      udf_nxt = 1'b0;
    end
    if (load_now)
    begin
      cnt_nxt = manual_dly;
      ovf_nxt = 1'b0;
      udf_nxt = 1'b0;
    end
    else if (loop_en && !loop_load)
    begin
      if (late_s2_r && !early_s2_r)
      begin
        if (cnt_r == 8'hff)
          ovf_nxt = 1'b1;
        else
        begin
          cnt_nxt = cnt_r + 8'h01;
          ovf_nxt = 1'b0;
          udf_nxt = 1'b0;
        end
      end
      else if (early_s2_r && !late_s2_r)
      begin
        if (cnt_r == 8'h00)
          udf_nxt = 1'b1;
        else
        begin
          cnt_nxt = cnt_r - 8'h01;
          udf_nxt = 1'b0;
          ovf_nxt = 1'b0;
        end
      end
    end
    tap_nxt = loop_en ? cnt_nxt : manual_dly;
  end

  always_ff @(posedge ref_clk_in)
  begin
    if (rst_in)
    begin
      early_s1_r <= 1'b0;
      early_s2_r <= 1'b0;
      late_s1_r  <= 1'b0;
      late_s2_r  <= 1'b0;
      cnt_r      <= 8'h00;
      ovf_r      <= 1'b0;
      udf_r      <= 1'b0;
      tap_r      <= 8'h00;
    end
    else
    begin
      early_s1_r <= delay_early_in;
      early_s2_r <= early_s1_r;
      late_s1_r  <= delay_late_in;
      late_s2_r  <= late_s1_r;
      cnt_r      <= cnt_nxt;
      ovf_r      <= ovf_nxt;
      udf_r      <= udf_nxt;
      tap_r      <= tap_nxt;
    end
  end

  always_comb
  begin
    stat_word = 32'h0000_0000;
    stat_word[sdram_dll_mode_pkg::STAT_CNT_LSB +: 8] = cnt_r;
    stat_word[sdram_dll_mode_pkg::STAT_UDF_BIT]      = udf_r;
    stat_word[sdram_dll_mode_pkg::STAT_OVF_BIT]      = ovf_r;
    stat_word[sdram_dll_mode_pkg::STAT_LOCK_BIT]     = 1'b0;
  end
  assign delay_tap_out = tap_r;
  assign delay_target_out = !loop_en ? 8'h00
    : ctrl_r[sdram_dll_mode_pkg::CTRL_PHASE_BIT] ? TARGET_90
    : TARGET_72;
  assign write_clock_offset_out =
    ctrl_r[sdram_dll_mode_pkg::CTRL_WO_LSB +: 6];

  // ****************************************
  // load mode command issue
  // ****************************************
  typedef enum logic [2:0] {
    LM_IDLE  = 3'b001,
    LM_WAIT  = 3'b010,
    LM_ISSUE = 3'b100
  } lm_state_e;

  lm_state_e   lm_state_r, lm_state_nxt;
  logic        mode_pend_r, mode_pend_nxt;
  logic        ext_pend_r, ext_pend_nxt;
  logic        sel_ext_r, sel_ext_nxt;
  logic [3:0]  cmd_r, cmd_nxt;
  logic [1:0]  ba_r, ba_nxt;
  logic [11:0] addr_r, addr_nxt;

  always_comb
  begin
    lm_state_nxt  = lm_state_r;
    mode_pend_nxt = mode_pend_r | wr_mode;
    ext_pend_nxt  = ext_pend_r | wr_ext;
    sel_ext_nxt   = sel_ext_r;
    cmd_nxt       = 4'hf;
    ba_nxt        = 2'h0;
    addr_nxt      = 12'h000;
    case (lm_state_r)
      LM_IDLE:
      begin
        if (mode_pend_r || ext_pend_r)
        begin
          lm_state_nxt = LM_WAIT;
          sel_ext_nxt  = !mode_pend_r;
        end
      end
      LM_WAIT:
      begin
        if (banks_idle_in)
        begin
          lm_state_nxt = LM_ISSUE;
          cmd_nxt      = 4'h0;
          if (sel_ext_r)
          begin
            ba_nxt       = sdram_dll_mode_pkg::BA_EXT;
            addr_nxt     = 12'(ext_r[9:0]);
            ext_pend_nxt = wr_ext;
          end
          else
          begin
            ba_nxt        = sdram_dll_mode_pkg::BA_MODE;
            addr_nxt      = 12'(mode_r[9:0]);
            mode_pend_nxt = wr_mode;
          end
        end
      end
      LM_ISSUE: lm_state_nxt = LM_IDLE;
      default:  lm_state_nxt = LM_IDLE;
    endcase
  end

  always_ff @(posedge ref_clk_in)
  begin
    if (rst_in)
    begin
      lm_state_r  <= LM_IDLE;
      mode_pend_r <= 1'b0;
      ext_pend_r  <= 1'b0;
      sel_ext_r   <= 1'b0;
      cmd_r       <= 4'hf;
      ba_r        <= 2'h0;
      addr_r      <= 12'h000;
    end
    else
    begin
      lm_state_r  <= lm_state_nxt;
      mode_pend_r <= mode_pend_nxt;
      ext_pend_r  <= ext_pend_nxt;
      sel_ext_r   <= sel_ext_nxt;
      cmd_r       <= cmd_nxt;
      ba_r        <= ba_nxt;
      addr_r      <= addr_nxt;
    end
  end

  // other commands kept off the bus while waiting and issuing
  assign bus_hold_out = lm_state_r != LM_IDLE;
  assign {sdram_cs_n_out, sdram_ras_n_out, sdram_cas_n_out,
          sdram_we_n_out} = cmd_r;
  assign sdram_ba_out   = ba_r;
  assign sdram_addr_out = addr_r;

endmodule // sdram_dll_mode_load

// *** sdram_dll_mode_pkg.sv ***
/*
  constants shared by the delay loop and mode load block: register
  offsets, field positions, reset values and load mode bank addresses.
  assumes byte addresses on a 32-bit avalon-mm register bus.
*/
package sdram_dll_mode_pkg;

  // register byte offsets
  localparam logic [7:0] OFS_DLL_CTRL    = 8'h64;
  localparam logic [7:0] OFS_DLL_STAT    = 8'h68;
  localparam logic [7:0] OFS_MODE_NEW    = 8'h70;
  localparam logic [7:0] OFS_EXT_MODE    = 8'h74;
  localparam logic [7:0] OFS_MODE_LEGACY = 8'h24;

  // control register fields
  localparam int CTRL_ENABLE_BIT = 1;
  localparam int CTRL_PHASE_BIT  = 2;
  localparam int CTRL_LOAD_BIT   = 3;
  localparam int CTRL_DLY_LSB    = 8;
  localparam int CTRL_WO_LSB     = 20;
  localparam logic [31:0] CTRL_WMASK  = 32'h03f0_ff0e;
  localparam logic [31:0] CTRL_RESET  = 32'h0000_0000;

  // status register fields
  localparam int STAT_OVF_BIT  = 0;
  localparam int STAT_UDF_BIT  = 1;
  localparam int STAT_LOCK_BIT = 2;
  localparam int STAT_CNT_LSB  = 8;

  // mode register: cas latency 3, full page burst
  localparam logic [31:0] MODE_WMASK = 32'h0000_037f;
  localparam logic [31:0] MODE_RESET = 32'h0000_0037;
  localparam logic [31:0] EXT_WMASK  = 32'h0000_03ff;
  localparam logic [31:0] EXT_RESET  = 32'h0000_0000;

  // bank addresses of the two load mode targets
  localparam logic [1:0] BA_MODE = 2'h0;
  localparam logic [1:0] BA_EXT  = 2'h1;

  // phase targets as fractions of the clock period
  localparam int PHASE72_DIV = 5;
  localparam int PHASE90_DIV = 4;

endpackage

// *** dll_mode_properties.sv ***
/* port checks of the load mode path and register bus handshake.
   assumes binding onto sdram_dll_mode_load. */
module dll_mode_checker (
  input wire logic        ref_clk_in,
  input wire logic        rst_in,
  input wire logic [7:0]  avs_address_in,
  input wire logic        avs_read_in,
  input wire logic        avs_write_in,
  input wire logic        avs_waitrequest_out,
  input wire logic        banks_idle_in,
  input wire logic        bus_hold_out,
  input wire logic        sdram_cs_n_out,
  input wire logic        sdram_ras_n_out,
  input wire logic        sdram_cas_n_out,
  input wire logic        sdram_we_n_out,
  input wire logic [1:0]  sdram_ba_out,
  input wire logic [11:0] sdram_addr_out
);
  timeunit 1ns;
  timeprecision 1ns;
  wire logic cmd;
  wire logic ld_wr;
  assign cmd = !sdram_cs_n_out;
  assign ld_wr = avs_write_in && (avs_address_in == 8'h70 ||
    avs_address_in == 8'h24 || avs_address_in == 8'h74);
  default clocking cb @(posedge ref_clk_in);
  endclocking
  default disable iff (rst_in);
  cmd_pins_a: assert property (cmd |->
    !sdram_ras_n_out && !sdram_cas_n_out && !sdram_we_n_out)
    else $error("load mode pins not together");
  cmd_single_a: assert property (cmd |=> !cmd)
    else $error("load mode longer than one cycle");
  cmd_idle_a: assert property (cmd |-> $past(banks_idle_in))
    else $error("load mode without idle banks");
  cmd_bank_a: assert property (cmd |-> !sdram_ba_out[1])
    else $error("bank line one high");
  cmd_addr_a: assert property (cmd |-> sdram_addr_out[11:10] == 2'h0)
    else $error("address top bits set");
  hold_cmd_a: assert property (cmd |-> bus_hold_out)
    else $error("bus not held in command");
  load_start_a: assert property (ld_wr |-> ##[1:2] bus_hold_out)
    else $error("mode write not pending");
  idle_issue_a: assert property
    (bus_hold_out && !cmd && banks_idle_in |=> cmd)
    else $error("idle banks but no command");
  write_nowait_a: assert property
    (avs_write_in |-> !avs_waitrequest_out)
    else $error("write stalled");
  cover property (cmd && sdram_ba_out == 2'h1);
  cover property (bus_hold_out && !banks_idle_in);
  cover property (avs_read_in && !avs_waitrequest_out);
endmodule // dll_mode_checker

bind sdram_dll_mode_load dll_mode_checker u_chk (.*);

// *** sdram_mode_model.sv ***
/* memory side model: reports bank idle state, logs load mode.
   assumes the bench steers busy_in to stall the banks. */
module sdram_mode_model (
  input wire logic        clk_in,
  input wire logic        rst_in,
  input wire logic        busy_in,
  input wire logic        cs_n_in,
  input wire logic        ras_n_in,
  input wire logic        cas_n_in,
  input wire logic        we_n_in,
  input wire logic [1:0]  ba_in,
  input wire logic [11:0] addr_in,
  output logic            banks_idle_out
);
  timeunit 1ns;
  timeprecision 1ns;
  int          cmd_cnt;
  logic [1:0]  last_ba;
  logic [11:0] last_addr;
  assign banks_idle_out = !busy_in;
  always @(posedge clk_in)
  begin
    if (rst_in)
      cmd_cnt <= 0;
    else if (!(cs_n_in | ras_n_in | cas_n_in | we_n_in))
    begin
      cmd_cnt <= cmd_cnt + 1;
      last_ba <= ba_in;
      last_addr <= addr_in;
    end
  end
endmodule // sdram_mode_model

// *** testbench.sv ***
/* self-checking bench of sdram_dll_mode_load.
   assumes the memory model and bound checker are compiled. */
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 0, rst = 1, rd = 0, wr_r = 0, erl = 0, lat = 0, busy = 0;
  logic [7:0] adr = 8'h00;
  logic [31:0] wd = 32'h0, rdat, rv;
  logic wt, idle, hold, cs, ras, cas, we;
  logic [7:0] tap, tgt;
  logic [5:0] ofs;
  logic [1:0] ba;
  logic [11:0] ma;
  int error_cnt = 0, samples_checked = 0, c0;
  always #5 clk = ~clk;
  sdram_dll_mode_load u_dut (.ref_clk_in(clk), .rst_in(rst),
    .avs_address_in(adr), .avs_read_in(rd), .avs_write_in(wr_r),
    .avs_writedata_in(wd), .avs_byteenable_in(4'hf),
    .avs_readdata_out(rdat), .avs_waitrequest_out(wt),
    .delay_early_in(erl), .delay_late_in(lat), .banks_idle_in(idle),
    .bus_hold_out(hold), .delay_tap_out(tap), .delay_target_out(tgt),
    .write_clock_offset_out(ofs), .sdram_cs_n_out(cs),
    .sdram_ras_n_out(ras), .sdram_cas_n_out(cas), .sdram_we_n_out(we),
    .sdram_ba_out(ba), .sdram_addr_out(ma));
  sdram_mode_model u_mem (.clk_in(clk), .rst_in(rst), .busy_in(busy),
    .cs_n_in(cs), .ras_n_in(ras), .cas_n_in(cas), .we_n_in(we),
    .ba_in(ba), .addr_in(ma), .banks_idle_out(idle));
  task results;
    if (error_cnt == 0 && samples_checked > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task chk(input logic [31:0] s, input logic [31:0] e);
    samples_checked++;
    if (s !== e)
    begin
      error_cnt++;
      $display("BAD %0t seen %h want %h", $time, s, e);
    end
  endtask
  task tick(input int n);
    repeat (n) @(posedge clk);
  endtask
  task bus(input logic r, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    rd <= r;
    wr_r <= !r;
    adr <= a;
    wd <= d;
    do
      @(posedge clk);
    while (wt);
    rv = rdat;
    rd <= 0;
    wr_r <= 0;
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b0, a, d);
  endtask
  task rdc(input logic [7:0] a, input logic [31:0] e);
    bus(1'b1, a, 32'h0);
    chk(rv, e);
  endtask
  task mload(input logic [7:0] a, input logic [31:0] d,
             input logic [1:0] b, input logic [11:0] m);
    c0 = u_mem.cmd_cnt;
    wr(a, d);
    tick(8);
    chk(u_mem.cmd_cnt - c0, 1);
    chk(u_mem.last_ba, b);
    chk(u_mem.last_addr, m);
  endtask
  task t_reset;
    rdc(8'h64, 32'h0);
    rdc(8'h68, 32'h0);
    rdc(8'h70, 32'h37);
    rdc(8'h74, 32'h0);
  endtask
  task t_mode;
    mload(8'h70, 32'h137, 2'h0, 12'h137);
    mload(8'h24, 32'hffff_0023, 2'h0, 12'h023);
    rdc(8'h70, 32'h23);
    mload(8'h74, 32'h3f8, 2'h1, 12'h3f8);
    mload(8'h74, 32'h7, 2'h1, 12'h007);
    rdc(8'h74, 32'h7);
  endtask
  task t_busy;
    busy <= 1;
    c0 = u_mem.cmd_cnt;
    wr(8'h70, 32'h33);
    wr(8'h70, 32'h37);
    tick(10);
    chk(u_mem.cmd_cnt - c0, 0);
    busy <= 0;
    tick(6);
    chk(u_mem.cmd_cnt - c0, 1);
    chk(u_mem.last_addr, 12'h037);
  endtask
  task t_dll;
    wr(8'h64, 32'hfd0a);
    tick(4);
    rdc(8'h68, 32'hfd00);
    lat <= 1;
    tick(12);
    rdc(8'h68, 32'hfd00);
    chk(tap, 8'hfd);
    wr(8'h64, 32'hfd02);
    tick(12);
    rdc(8'h68, 32'hff01);
    lat <= 0;
    wr(8'h64, 32'h020a);
    tick(4);
    rdc(8'h68, 32'h0200);
    erl <= 1;
    wr(8'h64, 32'h0202);
    tick(12);
    rdc(8'h68, 32'h0002);
    erl <= 0;
    wr(8'h64, 32'h02a0_3304);
    tick(3);
    chk(tgt, 8'h0);
    chk(tap, 8'h33);
    chk(ofs, 6'h2a);
    wr(8'h64, 32'h02a0_3306);
    tick(3);
    chk(tgt, 8'(152 / 4));
    wr(8'h64, 32'h02a0_3302);
    tick(3);
    chk(tgt, 8'(152 / 5));
    wr(8'h64, 32'hffff_ffff);
    rdc(8'h64, 32'h03f0_ff0e);
    wr(8'h68, 32'hffff_ffff);
    tick(4);
    rdc(8'h68, 32'hff00);
    rdc(8'h40, 32'h0);
  endtask
  initial
  begin
    tick(5);
    rst <= 0;
    t_reset;
    t_mode;
    t_busy;
    t_dll;
    results;
  end
  initial
  begin
    tick(20000);
    error_cnt++;
    results;
  end
endmodule // testbench
